// file: src/sacf_frame.sv
// Purpose: digital side of an eight-channel 12-bit SAR converter with serial result output
// Assumes: pins are sampled by CLK; serial clock well below a third of CLK
// Notes:   analog mux, DAC and comparator sit outside; the DAC adds the half-step offset
`timescale 1ns/1ps
`default_nettype none
`include "sacf_map.svh"

// What this block does
// - eight channels share one SAR core giving a 12-bit result per conversion
// - one result every 16 serial clocks, up to one million samples per second
// - results are unsigned straight binary, zero at the bottom of range
// - one code step is analog supply over 4096; twelve bits span it
// - first transition at half a step, each later one a full step on
// - transitions midway between integer step voltages, half-step offset
// - frame runs chip-select fall to rise, whole multiples of 16 rising edges
// - track three clocks, convert thirteen; four zeros then result MSB first
// - first eight rising edges load control byte; bits 5..3 pick next channel
// - output driven only while chip select low; high gates the serial clock
module sacf_frame #(
  parameter int RES_W      = 12,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 ARST_N,
  // serial pins
  input  wire logic                 CS_N,
  input  wire logic                 SCLK,
  input  wire logic                 DIN,
  output logic                      DOUT,
  output logic                      DOUT_OE,
  // analog core
  output logic [2:0]                CHANNEL_SEL,
  output logic                      TRACK,
  output logic [RES_W-1:0]          TRIAL_CODE,
  input  wire logic                 COMP_ABOVE,
  // result stream
  output logic                      RESULT_VALID,
  input  wire logic                 RESULT_READY,
  output sacf_pkg::sacf_result_t    RESULT_DATA,
  output logic                      OVERRUN
);
  import sacf_pkg::*;

  // the trial code and result word are laid out for twelve bits
  if (RES_W != 12) begin : g_bad_width
    $error("sacf_frame serves a 12-bit result only");
  end

  // one SAR step: settle bit b, then try the next lower bit
  function automatic logic [11:0] sar_step(input logic [11:0] trial, input logic [3:0] b, input logic above);
    logic [11:0] t;
    t    = trial;
    t[b] = above;
    if (b != 4'h0) t[b-4'h1] = 1'b1;
    return t;
  endfunction

  // three-stage pin sampling with agreement filter
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] pin_q;
  wire  [2:0] pin_d = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_q  <= `SACF_PIN_IDLE;
      s2_q  <= `SACF_PIN_IDLE;
      s3_q  <= `SACF_PIN_IDLE;
      pin_q <= `SACF_PIN_IDLE;
    end else begin
      s1_q  <= {DIN, SCLK, CS_N};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end

  // frame and serial clock events
  logic [4:0]  fall_cnt_q;
  logic [4:0]  fall_cnt_d;
  wire         act_d     = !pin_d[`SACF_PIN_CS];
  wire         start_ev  = pin_q[`SACF_PIN_CS] && act_d;
  wire         sclk_fall = pin_q[`SACF_PIN_SCLK] && !pin_d[`SACF_PIN_SCLK];
  wire         sclk_rise = !pin_q[`SACF_PIN_SCLK] && pin_d[`SACF_PIN_SCLK];
  // chip select low with clock low counts as the first falling edge
  wire         start_low = start_ev && !pin_d[`SACF_PIN_SCLK];
  wire         fall_ev   = act_d && !start_ev && sclk_fall;
  wire         rise_ev   = act_d && !start_ev && sclk_rise && (fall_cnt_q != 5'd0);
  wire         enter     = start_low || fall_ev;
  wire         in_zeros  = (fall_cnt_d <= `SACF_ZERO_LAST);
  wire [3:0]   bit_idx   = 4'(`SACF_CONV_CLKS - fall_cnt_d);

  // falling-edge index within the current conversion, wraps after 16
  assign fall_cnt_d = !act_d     ? 5'd0 :
                      start_ev   ? (start_low ? 5'd1 : 5'd0) :
                      fall_ev    ? ((fall_cnt_q == `SACF_CONV_CLKS) ? 5'd1 :
                                    fall_cnt_q + 5'd1) :
                      fall_cnt_q;

  // converter state
  logic [7:0]        ctrl_q;
  logic [2:0]        next_chan_q;
  logic [2:0]        chan_q;
  logic [11:0]       trial_q;
  logic [11:0]       trial_d;
  logic              dout_q;
  logic              oe_q;
  logic              overrun_q;
  logic              push;
  logic              push_ready;
  sacf_result_t      push_word;

  // SAR walk: load at hold start, one bit per falling edge from the fifth
  assign trial_d = !enter                         ? trial_q :
                   (fall_cnt_d == `SACF_HOLD_FALL) ? `SACF_TRIAL_START :
                   in_zeros                        ? trial_q :
                   sar_step(trial_q, bit_idx, COMP_ABOVE);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fall_cnt_q <= 5'd0;
      trial_q    <= 12'h000;
    end else begin
      fall_cnt_q <= fall_cnt_d;
      trial_q    <= trial_d;
    end
  end

  // serial output: zeros on edges 1..4, decided bits MSB first on 5..16
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      oe_q <= act_d;
      if (!act_d) dout_q <= 1'b0;
      else if (enter) dout_q <= in_zeros ? 1'b0 : COMP_ABOVE;
    end
  end

  // control byte on rising edges 1..8; channel taken at the next conversion
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q      <= 8'h00;
      next_chan_q <= 3'h0;
      chan_q      <= 3'h0;
    end else begin
      if (rise_ev && fall_cnt_q <= `SACF_CTRL_LAST)
        ctrl_q <= {ctrl_q[6:0], pin_d[`SACF_PIN_DIN]};
      if (rise_ev && fall_cnt_q == `SACF_CTRL_LAST)
        next_chan_q <= ctrl_q[`SACF_CHAN_MSB-1:`SACF_CHAN_LSB-1];
      if (enter && fall_cnt_d == 5'd1)
        chan_q <= next_chan_q;
    end
  end

  // a finished code leaves on the sixteenth rising edge
  assign push           = rise_ev && (fall_cnt_q == `SACF_CONV_CLKS);
  assign push_word      = '{chan: chan_q, code: trial_q};

  // full buffer drops the word and flags it for one cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) overrun_q <= 1'b0;
    else         overrun_q <= push && !push_ready;
  end

  sacf_fifo #(
    .W     ($bits(sacf_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (RESULT_VALID),
    .out_ready (RESULT_READY),
    .out_data  (RESULT_DATA)
  );

  // outputs
  assign DOUT        = dout_q;
  assign DOUT_OE     = oe_q;
  assign CHANNEL_SEL = chan_q;
  assign TRIAL_CODE  = trial_q;
  assign OVERRUN     = overrun_q;
  assign TRACK       = oe_q && (fall_cnt_q != 5'd0) && (fall_cnt_q <= `SACF_TRACK_LAST);

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_last_track;
    fall_ev && fall_cnt_q == 5'd3;
  endsequence
  sequence s_hold_loaded;
    ##1 (trial_q == 12'h800) && !TRACK;
  endsequence

  a_hold_start_load : assert property (s_last_track |-> s_hold_loaded)
    else $error("hold did not start with the top trial bit");
  a_dout_off_idle : assert property (!act_d |=> !DOUT_OE && !DOUT)
    else $error("serial output driven with chip select high");
  a_lead_zeros : assert property (enter && fall_cnt_d >= 5'd1 && fall_cnt_d <= 5'd4 |=> DOUT == 1'b0)
    else $error("leading zero missing");
  a_dout_bit : assert property (enter && fall_cnt_d >= 5'd5 |=> DOUT == $past(COMP_ABOVE)
    && TRIAL_CODE[4'(`SACF_CONV_CLKS - $past(fall_cnt_d))] == DOUT)
    else $error("shifted bit differs from decided bit");
  a_count_range : assert property (fall_cnt_q <= 5'd16)
    else $error("conversion count past sixteen");
  a_frame_clear : assert property (!act_d |=> fall_cnt_q == 5'd0 && !TRACK)
    else $error("frame state kept after chip select rise");
  a_chan_latch : assert property (rise_ev && fall_cnt_q == `SACF_CTRL_LAST |=>
    next_chan_q == ctrl_q[`SACF_CHAN_MSB:`SACF_CHAN_LSB])
    else $error("channel field not taken from control byte");
  a_push_edge : assert property (push |-> (fall_cnt_q == 5'd16 && rise_ev) ##1 (fall_cnt_q == 5'd16 || fall_cnt_q == 5'd0))
    else $error("result pushed outside the sixteenth rising edge");
  a_chan_steady : assert property (!(enter && fall_cnt_d == 5'd1) |=> $stable(CHANNEL_SEL))
    else $error("channel changed inside a conversion");
  a_drop_flag : assert property (push && !push_ready |=> OVERRUN ##1 (!OVERRUN || push))
    else $error("dropped result not flagged");
endmodule // sacf_frame
`default_nettype wire

// file: src/sacf_map.svh
// Purpose: named positions and counts for the serial conversion frame
// Assumes: included by its bare name from the design files
// Notes:   definitions only
`ifndef SACF_MAP_SVH
`define SACF_MAP_SVH

// serial clocks in one conversion
`define SACF_CONV_CLKS      5'd16
// last falling edge of the track phase
`define SACF_TRACK_LAST     5'd3
// falling edge that starts hold and convert
`define SACF_HOLD_FALL      5'd4
// last falling edge that shifts out a leading zero
`define SACF_ZERO_LAST      5'd4
// rising edge that completes the control byte
`define SACF_CTRL_LAST      5'd8
// channel field inside the control byte
`define SACF_CHAN_MSB       5
`define SACF_CHAN_LSB       3
// trial code loaded at the start of hold
`define SACF_TRIAL_START    12'h800
// index of the synchronised pins in the pin vector
`define SACF_PIN_CS         0
`define SACF_PIN_SCLK       1
`define SACF_PIN_DIN        2
// reset state of the pin filter: chip select high, clock and data low
`define SACF_PIN_IDLE       3'h1

`endif

// file: src/sacf_pkg.sv
// Purpose: shared types of the serial conversion frame
// Assumes: nothing
// Notes:   one result word as it leaves the block
package sacf_pkg;

  // converted channel and its straight-binary code
  typedef struct packed {
    logic [2:0]  chan;
    logic [11:0] code;
  } sacf_result_t;

endpackage

// file: src/sacf_fifo.sv
// Purpose: result buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module sacf_fifo #(
  parameter int W     = 15,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  import sacf_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sacf_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire          empty = (wr_q == rd_q);
  wire          push  = in_valid && !full;
  wire          pop   = out_valid && out_ready;

  // handshake and head word
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  // pointers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end

  a_fifo_no_overfill : assert property (@(posedge clk) disable iff (!arst_n)
    full |-> !in_ready && ((wr_q - rd_q) == (AW+1)'(DEPTH)))
    else $error("fifo full but still accepting");
endmodule // sacf_fifo
`default_nettype wire

// file: verif/sacf_host.sv
// Purpose: host serial master driving chip select, serial clock and control data
// Assumes: each clock phase lasts 4 CLK, a 400 ns serial period
// Notes:   reads each result bit just before the next falling edge
`timescale 1ns/1ps
`default_nettype none
module sacf_host (
  // system clock
  input  wire logic clk,
  // serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  bit lead;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // equal phases keep the duty at half and the rate at 2.5 MHz
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // clock held low, so the select fall counts as falling edge 1
  task automatic start();
    @(posedge clk);
    cs_n <= 1'b0;
    lead = 1'b1;
  endtask

  // n serial clocks, control byte msb first on the first eight rises
  task automatic conv(input logic [7:0] c, input int n, output logic [15:0] q);
    q = 16'h0;
    for (int k = 0; k < n; k++) begin
      if (!lead) sclk <= 1'b0;
      lead = 1'b0;
      din <= (k < 8) ? c[7-k] : ~din;
      half();
      sclk <= 1'b1;
      half();
      q = {q[14:0], dout};
    end
  endtask

  // select rises with the clock high, then the clock parks low
  task automatic stop();
    cs_n <= 1'b1;
    half();
    sclk <= 1'b0;
    din  <= ~din;
    half();
  endtask
endmodule  // sacf_host
`default_nettype wire

// file: verif/serial_adc_conversion_frame_tb.sv
// Purpose: self-checking bench of the serial conversion frame
// Assumes: 20 MHz clock, host model on the serial pins, ideal comparator
// Notes:   rows run as one continuous frame, awkward cases follow
`timescale 1ns/1ps
`default_nettype none
module serial_adc_conversion_frame_tb;
  import sacf_pkg::*;
  typedef struct packed { logic [7:0] ctl; logic [11:0] code; logic [2:0] chan; } sacf_row_t;
  logic clk = 1'b0, arst_n = 1'b0, comp = 1'b0, rdy = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, track, result_valid, overrun;
  logic [2:0]   chan_sel;
  logic [11:0]  trial, target = 12'h0;
  logic [15:0]  q;
  sacf_result_t result_data;
  sacf_result_t res_q[$];
  int n_errors = 0, n_checks = 0, n_ov = 0, n_trk = 0;
  // control byte, analog level as a code, channel expected in the result
  sacf_row_t rows[9] = '{'{8'hC8, 12'h000, 3'd0}, '{8'h17, 12'hFFF, 3'd1}, '{8'h18, 12'h800, 3'd2},
    '{8'h20, 12'h7FF, 3'd3}, '{8'hEF, 12'h001, 3'd4}, '{8'h30, 12'hA5A, 3'd5},
    '{8'h38, 12'h5A5, 3'd6}, '{8'h00, 12'hFFE, 3'd7}, '{8'h08, 12'h123, 3'd0}};

  initial begin
    forever #25 clk = ~clk;
  end

  sacf_frame u_sacf_frame (.CLK(clk), .ARST_N(arst_n), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .DOUT(dout), .DOUT_OE(dout_oe), .CHANNEL_SEL(chan_sel), .TRACK(track), .TRIAL_CODE(trial),
    .COMP_ABOVE(comp), .RESULT_VALID(result_valid), .RESULT_READY(rdy), .RESULT_DATA(result_data),
    .OVERRUN(overrun));
  // released pin reads as the inverse of dout, which is held at 0 while released, so as 1
  wire dout_pin = dout_oe ? dout : ~dout;
  sacf_host u_sacf_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_pin));

  // ideal comparator and result collector
  always @(posedge clk) begin
    comp <= (target >= trial);
    if (result_valid === 1'b1 && rdy) res_q.push_back(result_data);
    if (overrun === 1'b1) n_ov++;
    if (track === 1'b1) n_trk++;
  end

  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk_w({15'h0, g}, {15'h0, e});
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #1000000;
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk_bit(dout_oe, 1'b0);
    chk_bit(result_valid, 1'b0);
    rdy <= 1'b1;
    // table rows back to back in one frame
    u_sacf_host.start();
    foreach (rows[i]) begin
      target <= rows[i].code;
      u_sacf_host.conv(rows[i].ctl, 16, q);
      chk_w(q, {4'h0, rows[i].code});
      chk_bit(dout_oe, 1'b1);
      chk_w({13'h0, chan_sel}, {13'h0, rows[i].chan});
      chk_w({4'h0, trial}, {4'h0, rows[i].code});
    end
    u_sacf_host.stop();
    repeat (8) @(posedge clk);
    chk_bit(dout_oe, 1'b0);
    chk_w(16'(n_trk), 16'(9 * 3 * 8));
    chk_w(16'(res_q.size()), 16'd9);
    foreach (rows[i]) chk_w({1'b0, res_q.pop_front()}, {1'b0, rows[i].chan, rows[i].code});
    // cut-off conversion leaves no result
    u_sacf_host.start();
    u_sacf_host.conv(8'h08, 8, q);
    u_sacf_host.stop();
    repeat (8) @(posedge clk);
    chk_w(16'(res_q.size()), 16'd0);
    // consumer stalls through 17 conversions: 16 kept, one dropped
    rdy <= 1'b0;
    target <= 12'h3C3;
    u_sacf_host.start();
    repeat (17) u_sacf_host.conv(8'h08, 16, q);
    u_sacf_host.stop();
    chk_w(16'(n_ov), 16'd1);
    rdy <= 1'b1;
    repeat (24) @(posedge clk);
    chk_w(16'(res_q.size()), 16'd16);
    chk_bit(result_valid, 1'b0);
    while (res_q.size() > 0) chk_w({1'b0, res_q.pop_front()}, {1'b0, 3'd1, 12'h3C3});
    // reset inside a frame: outputs clear, the latched channel returns to 0
    u_sacf_host.start();
    u_sacf_host.conv(8'h18, 10, q);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_bit(dout_oe, 1'b0);
    chk_bit(track, 1'b0);
    chk_w({4'h0, trial}, 16'h0000);
    chk_w({13'h0, chan_sel}, 16'h0000);
    u_sacf_host.stop();
    arst_n <= 1'b1;
    @(posedge clk);
    chk_bit(dout_oe, 1'b0);
    @(posedge clk);
    chk_bit(result_valid, 1'b0);
    target <= 12'h6B9;
    u_sacf_host.start();
    u_sacf_host.conv(8'h08, 16, q);
    chk_w(q, 16'h06B9);
    chk_w({13'h0, chan_sel}, 16'h0000);
    u_sacf_host.stop();
    repeat (8) @(posedge clk);
    chk_w(16'(res_q.size()), 16'd1);
    if (res_q.size() > 0) chk_w({1'b0, res_q.pop_front()}, {1'b0, 3'd0, 12'h6B9});
    stop_test();
  end
endmodule  // serial_adc_conversion_frame_tb
`default_nettype wire
